//--- odh_pkg.sv
package odh_pkg;

    // ==========================================================
    // Bus widths.
    // ==========================================================
    localparam int ODH_DATA_W = 8;

    // ==========================================================
    // Host port selection decoded from the straps.
    // ==========================================================
    typedef enum logic [1:0] {
        ODH_PORT_SERIAL   = 2'h0,
        ODH_PORT_I2C      = 2'h1,
        ODH_PORT_PARALLEL = 2'h3
    } odh_port_e;

    // ==========================================================
    // Transfer engine states, Gray coded along idle, write, read.
    // ==========================================================
    typedef enum logic [1:0] {
        ODH_ST_IDLE  = 2'h0,
        ODH_ST_WRITE = 2'h1,
        ODH_ST_READ  = 2'h3
    } odh_state_e;

    // ==========================================================
    // Reset values and synchroniser settings.
    // ==========================================================
    localparam logic [7:0] ODH_BYTE_RST = 8'h00;
    localparam logic [2:0] ODH_SYNC_RST = 3'h0;
    localparam logic [2:0] ODH_SYNC_IDLE_HIGH = 3'h7;
    localparam int ODH_SYNC_MID = 1;
    localparam int ODH_SYNC_LAST = 2;

endpackage

//--- odh_host_port.sv
`timescale 1ns/1ps
`default_nettype none

module odh_host_port
    import odh_pkg::*;
(
    input wire logic clock_i,
    input wire logic arst_n_i,
    // Straps, read once after reset release.
    input wire logic parallel_port_strap_i,
    input wire logic i2c_port_strap_i,
    input wire logic bus_protocol_strap_i,
    input wire logic internal_osc_enable_strap_i,
    // Host pins.
    input wire logic chip_select_n_i,
    input wire logic enable_read_strobe_i,
    input wire logic direction_write_strobe_i,
    input wire logic data_command_select_i,
    input wire logic chip_init_input_n_i,
    input wire logic [7:0] host_data_bus_i,
    output logic [7:0] host_data_bus_o,
    output logic host_data_bus_oe_o,
    // Core side.
    input wire logic [7:0] read_data_i,
    output logic read_req_o,
    output logic [7:0] write_data_o,
    output logic display_write_o,
    output logic command_write_o,
    output logic init_active_o,
    output logic internal_osc_enable_o,
    output logic [1:0] host_port_o,
    output logic protocol_6800_o
);

    // ==========================================================
    // Pin synchronisers.
    // ==========================================================
    // Three stages per strobe and select pin; a change counts when stages two and three agree.
    logic [2:0] cs_sync;
    logic [2:0] e_sync;
    logic [2:0] w_sync;
    logic [2:0] rs_sync;
    logic [2:0] init_sync;
    logic cs_n;
    logic e_lvl;
    logic w_lvl;
    logic rs_lvl;
    logic init_n;
    logic [7:0] bus_s1;
    logic [7:0] bus_s2;

    // Strobes and selects, shifted every clock.
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            cs_sync <= ODH_SYNC_IDLE_HIGH;
            e_sync <= ODH_SYNC_RST;
            w_sync <= ODH_SYNC_RST;
            rs_sync <= ODH_SYNC_RST;
            init_sync <= ODH_SYNC_RST;
        end else begin
            cs_sync <= {cs_sync[1:0], chip_select_n_i};
            e_sync <= {e_sync[1:0], enable_read_strobe_i};
            w_sync <= {w_sync[1:0], direction_write_strobe_i};
            rs_sync <= {rs_sync[1:0], data_command_select_i};
            init_sync <= {init_sync[1:0], chip_init_input_n_i};
        end
    end

    // Filtered levels: hold the old value while stages two and three disagree.
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            cs_n <= 1'b1;
            e_lvl <= 1'b0;
            w_lvl <= 1'b0;
            rs_lvl <= 1'b0;
            init_n <= 1'b0;
        end else begin
            if (cs_sync[ODH_SYNC_MID] == cs_sync[ODH_SYNC_LAST]) begin
                cs_n <= cs_sync[ODH_SYNC_LAST];
            end
            if (e_sync[ODH_SYNC_MID] == e_sync[ODH_SYNC_LAST]) begin
                e_lvl <= e_sync[ODH_SYNC_LAST];
            end
            if (w_sync[ODH_SYNC_MID] == w_sync[ODH_SYNC_LAST]) begin
                w_lvl <= w_sync[ODH_SYNC_LAST];
            end
            if (rs_sync[ODH_SYNC_MID] == rs_sync[ODH_SYNC_LAST]) begin
                rs_lvl <= rs_sync[ODH_SYNC_LAST];
            end
            if (init_sync[ODH_SYNC_MID] == init_sync[ODH_SYNC_LAST]) begin
                init_n <= init_sync[ODH_SYNC_LAST];
            end
        end
    end

    // Data bus is held stable by the host around the strobe edge, so two
    // stages keep it aligned with the filtered strobes.
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            bus_s1 <= ODH_BYTE_RST;
            bus_s2 <= ODH_BYTE_RST;
        end else begin
            bus_s1 <= host_data_bus_i;
            bus_s2 <= bus_s1;
        end
    end

    // ==========================================================
    // Strap capture.
    // ==========================================================
    // Straps are caught on the first edge after release, never under reset.
    logic strap_taken;
    odh_port_e port_mode;
    logic mode_6800;

    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            strap_taken <= 1'b0;
            port_mode <= ODH_PORT_SERIAL;
            mode_6800 <= 1'b0;
            internal_osc_enable_o <= 1'b0;
        end else if (!strap_taken) begin
            strap_taken <= 1'b1;
            if (parallel_port_strap_i) begin
                port_mode <= ODH_PORT_PARALLEL;
            end else if (i2c_port_strap_i) begin
                port_mode <= ODH_PORT_I2C;
            end else begin
                port_mode <= ODH_PORT_SERIAL;
            end
            // The protocol strap is sampled even when unused; it must not float.
            mode_6800 <= bus_protocol_strap_i;
            internal_osc_enable_o <= internal_osc_enable_strap_i;
        end
    end

    assign host_port_o = port_mode;
    assign protocol_6800_o = mode_6800;

    // ==========================================================
    // Strobe decode.
    // ==========================================================
    // Active means the strobe is in its asserting phase for this protocol.
    logic par_on;
    logic rd_active;
    logic wr_active;

    always_comb begin
        par_on = strap_taken && (port_mode == ODH_PORT_PARALLEL) && init_n;
        if (mode_6800) begin
            rd_active = e_lvl && w_lvl;
            wr_active = e_lvl && !w_lvl;
        end else begin
            rd_active = !e_lvl;
            wr_active = !w_lvl;
        end
        // Serial and I2C ports never read; the board grounds both strobes.
        if (!par_on || cs_n) begin
            rd_active = 1'b0;
            wr_active = 1'b0;
        end
    end

    // ==========================================================
    // Transfer engine.
    // ==========================================================
    odh_state_e state;
    odh_state_e next_state;

    // A write commits when its strobe phase ends; losing chip select first
    // aborts it silently, as does an initialisation pulse.
    always_comb begin
        next_state = state;
        case (state)
            ODH_ST_IDLE: begin
                if (wr_active) begin
                    next_state = ODH_ST_WRITE;
                end else if (rd_active) begin
                    next_state = ODH_ST_READ;
                end
            end
            ODH_ST_WRITE: begin
                if (!wr_active) begin
                    next_state = ODH_ST_IDLE;
                end
            end
            ODH_ST_READ: begin
                if (!rd_active) begin
                    next_state = ODH_ST_IDLE;
                end
            end
            default: begin
                next_state = ODH_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state <= ODH_ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // Byte and select are latched during the strobe, then posted at its end.
    logic [7:0] wr_byte;
    logic wr_is_data;

    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            wr_byte <= ODH_BYTE_RST;
            wr_is_data <= 1'b0;
        end else if (wr_active) begin
            wr_byte <= bus_s2;
            wr_is_data <= rs_lvl;
        end
    end

    // Trailing strobe edge with chip select still low posts one pulse.
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            write_data_o <= ODH_BYTE_RST;
            display_write_o <= 1'b0;
            command_write_o <= 1'b0;
        end else begin
            display_write_o <= 1'b0;
            command_write_o <= 1'b0;
            if (state == ODH_ST_WRITE && !wr_active && !cs_n && par_on) begin
                write_data_o <= wr_byte;
                display_write_o <= wr_is_data;
                command_write_o <= !wr_is_data;
            end
        end
    end

    // ==========================================================
    // Read path and bus drive.
    // ==========================================================
    // The core sees read_req_o held for the whole read strobe and returns
    // read_data_i combinationally; the pin is driven one clock later.
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            read_req_o <= 1'b0;
            host_data_bus_o <= ODH_BYTE_RST;
            host_data_bus_oe_o <= 1'b0;
        end else begin
            read_req_o <= rd_active;
            host_data_bus_oe_o <= rd_active;
            if (rd_active) begin
                host_data_bus_o <= read_data_i;
            end else begin
                host_data_bus_o <= ODH_BYTE_RST;
            end
        end
    end

    // ==========================================================
    // Initialisation.
    // ==========================================================
    // Initialisation runs for as long as the filtered init pin is low.
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            init_active_o <= 1'b1;
        end else begin
            init_active_o <= !init_n;
        end
    end

endmodule

`default_nettype wire

//--- odh_host_port_properties.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Port checker for the host port, bound to every instance.
// ==========================================================
module odh_host_port_properties
    import odh_pkg::*;
(
    input wire logic clock_i,
    input wire logic arst_n_i,
    input wire logic chip_select_n_i,
    input wire logic data_command_select_i,
    input wire logic chip_init_input_n_i,
    input wire logic [7:0] read_data_i,
    input wire logic [7:0] host_data_bus_o,
    input wire logic host_data_bus_oe_o,
    input wire logic read_req_o,
    input wire logic [7:0] write_data_o,
    input wire logic display_write_o,
    input wire logic command_write_o,
    input wire logic init_active_o,
    input wire logic [1:0] host_port_o
);
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!arst_n_i);
    // A display byte needs the data select high and never doubles as a command.
    property p_disp;
        display_write_o |-> data_command_select_i && !command_write_o;
    endproperty
    a_disp: assert property (p_disp) else $error("display pulse with command select");
    property p_cmd;
        command_write_o |-> !data_command_select_i;
    endproperty
    a_cmd: assert property (p_cmd) else $error("command pulse with data select");
    property p_pulse;
        (display_write_o || command_write_o) |=> !display_write_o && !command_write_o;
    endproperty
    a_pulse: assert property (p_pulse) else $error("write pulse longer than one cycle");
    property p_wdata;
        $changed(write_data_o) |-> display_write_o || command_write_o;
    endproperty
    a_wdata: assert property (p_wdata) else $error("write byte moved without pulse");
    property p_rdmode;
        host_data_bus_oe_o |-> host_port_o == ODH_PORT_PARALLEL && !init_active_o;
    endproperty
    a_rdmode: assert property (p_rdmode) else $error("bus driven outside parallel mode");
    property p_rdsel;
        $rose(host_data_bus_oe_o) |-> !chip_select_n_i && read_req_o;
    endproperty
    a_rdsel: assert property (p_rdsel) else $error("bus driven while deselected");
    property p_rddata;
        host_data_bus_oe_o |-> host_data_bus_o == $past(read_data_i);
    endproperty
    a_rddata: assert property (p_rddata) else $error("read byte differs from core");
    property p_release;
        !host_data_bus_oe_o |-> host_data_bus_o == 8'h00;
    endproperty
    a_release: assert property (p_release) else $error("data left on idle bus");
    property p_init;
        !chip_init_input_n_i [*5] |=> init_active_o;
    endproperty
    a_init: assert property (p_init) else $error("init pin low but not initialising");
    c_disp: cover property (display_write_o);
    c_cmd: cover property (command_write_o);
    c_read: cover property ($rose(host_data_bus_oe_o));
endmodule
bind odh_host_port odh_host_port_properties u_props (.*);
`default_nettype wire

//--- odh_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Host controller model; strobe phases of 12 cycles outlast the pin filters.
// ==========================================================
module odh_host_model (
    input wire logic clock_i,
    input wire logic proto_6800_i,
    input wire logic grounded_i,
    input wire logic [7:0] bus_i,
    output logic cs_n_o,
    output logic e_rd_o,
    output logic rw_wr_o,
    output logic dcs_o,
    output logic [7:0] data_o
);
    initial begin
        cs_n_o = 1'b1;
        dcs_o = 1'b0;
        data_o = 8'h00;
        e_rd_o = 1'b1;
        rw_wr_o = 1'b1;
    end
    // Idle strobes; a serial board grounds both pins.
    task automatic idle();
        e_rd_o = !grounded_i && !proto_6800_i;
        rw_wr_o = !grounded_i;
    endtask
    // One transfer; a released bus shows the inverse of the last byte.
    task automatic xfer(input logic sel, input logic rd, input logic dc,
                        input logic [7:0] b, output logic [7:0] seen);
        @(negedge clock_i);
        cs_n_o = !sel;
        dcs_o = dc;
        data_o = rd ? ~data_o : b;
        repeat (3) @(negedge clock_i);
        e_rd_o = proto_6800_i || !rd;
        rw_wr_o = rd;
        repeat (12) @(negedge clock_i);
        seen = bus_i;
        idle();
        repeat (3) @(negedge clock_i);
        cs_n_o = 1'b1;
        data_o = ~data_o;
        repeat (8) @(negedge clock_i);
    endtask
endmodule
`default_nettype wire

//--- oled_driver_host_interface_tb.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Host port bench: straps need a reset, so each mode is its own reset.
// ==========================================================
module oled_driver_host_interface_tb;
    import odh_pkg::*;
    logic clock_i = 1'b0;
    logic arst_n_i = 1'b0;
    logic par = 1'b1, i2c = 1'b0, proto = 1'b0, osc = 1'b0, init_n = 1'b1;
    logic cs_n, e_rd, rw_wr, dcs, oe, disp, cmd, init_a, osc_o, p6800, rreq;
    logic [7:0] hd, bus_o, wdata, rdata = 8'h00, seen;
    logic [1:0] port;
    wire logic [7:0] bus = oe ? bus_o : hd;
    int err_total = 0, total_checks = 0, n_disp = 0, n_cmd = 0, n_oe = 0, n_rq = 0, n, m;
    always #2 clock_i = ~clock_i;
    odh_host_port u_dut (.clock_i(clock_i), .arst_n_i(arst_n_i),
        .parallel_port_strap_i(par), .i2c_port_strap_i(i2c),
        .bus_protocol_strap_i(proto), .internal_osc_enable_strap_i(osc),
        .chip_select_n_i(cs_n), .enable_read_strobe_i(e_rd),
        .direction_write_strobe_i(rw_wr), .data_command_select_i(dcs),
        .chip_init_input_n_i(init_n), .host_data_bus_i(bus), .host_data_bus_o(bus_o),
        .host_data_bus_oe_o(oe), .read_data_i(rdata), .read_req_o(rreq),
        .write_data_o(wdata), .display_write_o(disp), .command_write_o(cmd),
        .init_active_o(init_a), .internal_osc_enable_o(osc_o), .host_port_o(port),
        .protocol_6800_o(p6800));
    odh_host_model u_host (.clock_i(clock_i), .proto_6800_i(proto), .grounded_i(!par),
        .bus_i(bus), .cs_n_o(cs_n), .e_rd_o(e_rd), .rw_wr_o(rw_wr), .dcs_o(dcs),
        .data_o(hd));
    // Pulses last one cycle, so they are counted at every rising edge.
    always @(posedge clock_i) begin
        n_disp += int'(disp === 1'b1);
        n_cmd += int'(cmd === 1'b1);
        n_oe += int'(oe === 1'b1);
        n_rq += int'(rreq === 1'b1);
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic rst(input logic [3:0] s);
        @(negedge clock_i);
        arst_n_i = 1'b0;
        {par, i2c, proto, osc} = s;
        // The model's strap inputs settle one edge later, so idle levels follow then.
        @(negedge clock_i);
        u_host.idle();
        repeat (19) @(negedge clock_i);
        arst_n_i = 1'b1;
        repeat (8) @(negedge clock_i);
    endtask
    task automatic tally_and_finish();
        if (err_total == 0 && total_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    initial begin
        rst(4'h9);
        chk({6'h00, port}, 8'h03);
        chk({7'h00, p6800}, 8'h00);
        chk({7'h00, osc_o}, 8'h01);
        u_host.xfer(1'b1, 1'b0, 1'b1, 8'hA5, seen);
        chk(8'(n_disp), 8'h01);
        chk(wdata, 8'hA5);
        u_host.xfer(1'b1, 1'b0, 1'b0, 8'h3C, seen);
        chk(8'(n_cmd), 8'h01);
        chk(wdata, 8'h3C);
        rdata = 8'h5A;
        u_host.xfer(1'b1, 1'b1, 1'b0, 8'h00, seen);
        chk(seen, 8'h5A);
        chk({7'h00, oe}, 8'h00);
        chk({7'h00, n_rq > 0}, 8'h01);
        n = n_oe;
        m = n_rq;
        u_host.xfer(1'b0, 1'b1, 1'b0, 8'h00, seen);
        u_host.xfer(1'b0, 1'b0, 1'b1, 8'h77, seen);
        chk(8'(n_oe - n), 8'h00);
        chk(8'(n_rq - m), 8'h00);
        chk(8'(n_disp), 8'h01);
        init_n = 1'b0;
        u_host.xfer(1'b1, 1'b0, 1'b1, 8'h11, seen);
        chk({7'h00, init_a}, 8'h01);
        chk(8'(n_disp), 8'h01);
        init_n = 1'b1;
        rst(4'hA);
        chk({7'h00, p6800}, 8'h01);
        chk({7'h00, osc_o}, 8'h00);
        u_host.xfer(1'b1, 1'b0, 1'b1, 8'hC3, seen);
        chk(8'(n_disp), 8'h02);
        chk(wdata, 8'hC3);
        rdata = 8'h96;
        u_host.xfer(1'b1, 1'b1, 1'b0, 8'h00, seen);
        chk(seen, 8'h96);
        rst(4'h4);
        chk({6'h00, port}, 8'h01);
        n = n_oe;
        m = n_rq;
        u_host.xfer(1'b1, 1'b1, 1'b0, 8'h00, seen);
        chk(8'(n_oe - n), 8'h00);
        chk(8'(n_rq - m), 8'h00);
        rst(4'h0);
        chk({6'h00, port}, 8'h00);
        tally_and_finish();
    end
endmodule
`default_nettype wire
